// [rtl/ueta_regs.sv]
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`include "ueta_defs.svh"
module ueta_regs (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [5:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   output logic      [15:0]            rx_fifo_byte_offset_o,
   output ueta_pkg::ueta_target_s      tx_target_o,
   output ueta_pkg::ueta_target_s      rx_target_o
);
   import ueta_pkg::*;

   logic [12:0] rx_fifo_start_reg, rx_fifo_start_next;
   logic [6:0]  tx_func_reg, tx_func_next, rx_func_reg, rx_func_next;
   logic [6:0]  tx_hub_reg, tx_hub_next, rx_hub_reg, rx_hub_next;
   logic [6:0]  tx_port_reg, tx_port_next, rx_port_reg, rx_port_next;
   logic        tx_mtt_reg, tx_mtt_next, rx_mtt_reg, rx_mtt_next;
   logic [1:0]  split_reg, split_next;
   logic [31:0] wb_dat_reg, wb_dat_next;
   ueta_bus_e   bus_reg, bus_next;
   logic [15:0] offs_reg, offs_next;
   ueta_target_s tx_t_reg, tx_t_next, rx_t_reg, rx_t_next;
   logic        req;
   logic        wr;

   assign req = wb_cyc_i && wb_stb_i && (bus_reg == UETA_IDLE);
   assign wr  = req && wb_we_i;

   always_comb begin
      rx_fifo_start_next = rx_fifo_start_reg;
      tx_func_next = tx_func_reg;
      rx_func_next = rx_func_reg;
      tx_hub_next  = tx_hub_reg;
      rx_hub_next  = rx_hub_reg;
      tx_port_next = tx_port_reg;
      rx_port_next = rx_port_reg;
      tx_mtt_next  = tx_mtt_reg;
      rx_mtt_next  = rx_mtt_reg;
      split_next   = split_reg;
      wb_dat_next  = 32'h00000000;
      bus_next     = UETA_IDLE;
      if (req) begin
         bus_next = UETA_ACK;
      end
      if (wr) begin
         case (wb_adr_i)
            `UETA_OFS_RX_FIFO_START: begin
               if (wb_sel_i[0]) begin
                  rx_fifo_start_next[7:0] = wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  rx_fifo_start_next[12:8] = wb_dat_i[12:8];
               end
            end
            `UETA_OFS_TX_TARGET_FUNCTION: begin
               if (wb_sel_i[0]) begin
                  tx_func_next = wb_dat_i[6:0];
               end
            end
            `UETA_OFS_TX_HUB_ADDRESS: begin
               if (wb_sel_i[0]) begin
                  tx_hub_next = wb_dat_i[6:0];
                  tx_mtt_next = wb_dat_i[`UETA_MULTI_TT_BIT];
               end
            end
            `UETA_OFS_TX_HUB_PORT_NUMBER: begin
               if (wb_sel_i[0]) begin
                  tx_port_next = wb_dat_i[6:0];
               end
            end
            `UETA_OFS_RX_TARGET_FUNCTION: begin
               if (wb_sel_i[0]) begin
                  rx_func_next = wb_dat_i[6:0];
               end
            end
            `UETA_OFS_RX_HUB_ADDRESS: begin
               if (wb_sel_i[0]) begin
                  rx_hub_next = wb_dat_i[6:0];
                  rx_mtt_next = wb_dat_i[`UETA_MULTI_TT_BIT];
               end
            end
            `UETA_OFS_RX_HUB_PORT_NUMBER: begin
               if (wb_sel_i[0]) begin
                  rx_port_next = wb_dat_i[6:0];
               end
            end
            `UETA_OFS_HOST_CONTROL: begin
               if (wb_sel_i[0]) begin
                  split_next = wb_dat_i[1:0];
               end
            end
            default: begin
            end
         endcase
      end
      if (req && !wb_we_i) begin
         case (wb_adr_i)
            `UETA_OFS_RX_FIFO_START:      wb_dat_next = {19'h00000, rx_fifo_start_reg};
            `UETA_OFS_TX_TARGET_FUNCTION: wb_dat_next = {25'h0000000, tx_func_reg};
            `UETA_OFS_TX_HUB_ADDRESS:     wb_dat_next = {24'h000000, tx_mtt_reg, tx_hub_reg};
            `UETA_OFS_TX_HUB_PORT_NUMBER: wb_dat_next = {25'h0000000, tx_port_reg};
            `UETA_OFS_RX_TARGET_FUNCTION: wb_dat_next = {25'h0000000, rx_func_reg};
            `UETA_OFS_RX_HUB_ADDRESS:     wb_dat_next = {24'h000000, rx_mtt_reg, rx_hub_reg};
            `UETA_OFS_RX_HUB_PORT_NUMBER: wb_dat_next = {25'h0000000, rx_port_reg};
            `UETA_OFS_HOST_CONTROL:       wb_dat_next = {30'h00000000, split_reg};
            default:                      wb_dat_next = 32'h00000000;
         endcase
      end
      // The granule shift makes the offset a multiple of eight bytes.
      offs_next = {rx_fifo_start_reg, 3'h0};
      // Hub fields always go out; split_enable is host control bit 0 for transmit and bit 1 for receive.
      tx_t_next = '{tx_func_reg, tx_hub_reg, tx_port_reg, tx_mtt_reg, split_reg[0]};
      rx_t_next = '{rx_func_reg, rx_hub_reg, rx_port_reg, rx_mtt_reg, split_reg[1]};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_fifo_start_reg <= `UETA_RST_FIFO_START;
         tx_func_reg <= `UETA_RST_ADDR7;
         rx_func_reg <= `UETA_RST_ADDR7;
         tx_hub_reg  <= `UETA_RST_ADDR7;
         rx_hub_reg  <= `UETA_RST_ADDR7;
         tx_port_reg <= `UETA_RST_ADDR7;
         rx_port_reg <= `UETA_RST_ADDR7;
         tx_mtt_reg  <= 1'b0;
         rx_mtt_reg  <= 1'b0;
         split_reg   <= 2'h0;
         wb_dat_reg  <= 32'h00000000;
         bus_reg     <= UETA_IDLE;
         offs_reg    <= 16'h0000;
         tx_t_reg    <= '0;
         rx_t_reg    <= '0;
      end else begin
         rx_fifo_start_reg <= rx_fifo_start_next;
         tx_func_reg <= tx_func_next;
         rx_func_reg <= rx_func_next;
         tx_hub_reg  <= tx_hub_next;
         rx_hub_reg  <= rx_hub_next;
         tx_port_reg <= tx_port_next;
         rx_port_reg <= rx_port_next;
         tx_mtt_reg  <= tx_mtt_next;
         rx_mtt_reg  <= rx_mtt_next;
         split_reg   <= split_next;
         wb_dat_reg  <= wb_dat_next;
         bus_reg     <= bus_next;
         offs_reg    <= offs_next;
         tx_t_reg    <= tx_t_next;
         rx_t_reg    <= rx_t_next;
      end
   end

   assign wb_dat_o = wb_dat_reg;
   // The acknowledge state's one-hot bit is the flop itself, so ack leaves with no logic behind it.
   assign wb_ack_o = bus_reg[1];
   assign rx_fifo_byte_offset_o = offs_reg;
   assign tx_target_o = tx_t_reg;
   assign rx_target_o = rx_t_reg;

   property p_offset;
      @(posedge clk_i) disable iff (rst_i)
      1 |=> (offs_reg == {$past(rx_fifo_start_reg), 3'h0});
   endproperty
   a_offset: assert property (p_offset) else $error("fifo offset wrong");

   property p_fifo_rsv;
      @(posedge clk_i) disable iff (rst_i)
      (wb_ack_o && wb_adr_i == `UETA_OFS_RX_FIFO_START) |-> (wb_dat_o[31:13] == 19'h00000);
   endproperty
   a_fifo_rsv: assert property (p_fifo_rsv) else $error("fifo reserved bits set");

   property p_fifo_wr;
      @(posedge clk_i) disable iff (rst_i)
      (wr && wb_adr_i == `UETA_OFS_RX_FIFO_START && wb_sel_i[1:0] == 2'h3)
         |=> (rx_fifo_start_reg == $past(wb_dat_i[12:0]));
   endproperty
   a_fifo_wr: assert property (p_fifo_wr) else $error("fifo start not written");

   property p_func_rd;
      @(posedge clk_i) disable iff (rst_i)
      (req && !wb_we_i && wb_adr_i == `UETA_OFS_TX_TARGET_FUNCTION)
         |=> wb_ack_o && (wb_dat_o == {25'h0000000, $past(tx_func_reg)});
   endproperty
   a_func_rd: assert property (p_func_rd) else $error("function read wrong");

   property p_func_out;
      @(posedge clk_i) disable iff (rst_i)
      ##1 (rx_target_o.function_address == $past(rx_func_reg));
   endproperty
   a_func_out: assert property (p_func_out) else $error("function output stale");

   property p_mtt;
      @(posedge clk_i) disable iff (rst_i)
      (wr && wb_adr_i == `UETA_OFS_RX_HUB_ADDRESS && wb_sel_i[0])
         |=> ##1 (rx_target_o.multi_translator == $past(wb_dat_i[7], 2));
   endproperty
   a_mtt: assert property (p_mtt) else $error("translator flag wrong");

   property p_port_wr;
      @(posedge clk_i) disable iff (rst_i)
      (wr && wb_adr_i == `UETA_OFS_TX_HUB_PORT_NUMBER && wb_sel_i[0])
         |=> ##1 (tx_target_o.hub_port == $past(wb_dat_i[6:0], 2));
   endproperty
   a_port_wr: assert property (p_port_wr) else $error("hub port wrong");

   property p_split;
      @(posedge clk_i) disable iff (rst_i)
      ##1 (tx_target_o.hub_address == $past(tx_hub_reg)
           && tx_target_o.split_enable == $past(split_reg[0]));
   endproperty
   a_split: assert property (p_split) else $error("split fields wrong");

   property p_ack_once;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

   c_write: cover property (@(posedge clk_i) wr ##1 wb_ack_o);
   c_read:  cover property (@(posedge clk_i) (req && !wb_we_i) ##1 wb_ack_o);
   c_mtt:   cover property (@(posedge clk_i) rx_mtt_reg && tx_mtt_reg);
endmodule

// [rtl/ueta_defs.svh]
`ifndef UETA_DEFS_SVH
`define UETA_DEFS_SVH
// Register byte offsets on the Wishbone slave, one aligned word each.
`define UETA_OFS_RX_FIFO_START      6'h00
`define UETA_OFS_TX_TARGET_FUNCTION 6'h04
`define UETA_OFS_TX_HUB_ADDRESS     6'h08
`define UETA_OFS_TX_HUB_PORT_NUMBER 6'h0C
`define UETA_OFS_RX_TARGET_FUNCTION 6'h10
`define UETA_OFS_RX_HUB_ADDRESS     6'h14
`define UETA_OFS_RX_HUB_PORT_NUMBER 6'h18
`define UETA_OFS_HOST_CONTROL       6'h1C
// Field positions and widths.
`define UETA_FIFO_START_W           13
`define UETA_ADDR7_W                7
`define UETA_MULTI_TT_BIT           7
`define UETA_GRANULE_SHIFT          3
`define UETA_FIFO_BYTE_W            16
// Reset values.
`define UETA_RST_FIFO_START         13'h0000
`define UETA_RST_ADDR7              7'h00
`endif

// [rtl/ueta_pkg.sv]
package ueta_pkg;
   typedef struct packed {
      logic [6:0] function_address;
      logic [6:0] hub_address;
      logic [6:0] hub_port;
      logic       multi_translator;
      logic       split_enable;
   } ueta_target_s;
   typedef enum logic [1:0] {
      UETA_IDLE = 2'b01,
      UETA_ACK  = 2'b10
   } ueta_bus_e;
endpackage

// [test/ueta_hub_model.sv]
`timescale 1ns/1ns
// Hub-side view of one endpoint: the split token fields that a hub would receive.
// Token layout {hub_address, hub_port, multi_translator, valid} is this model's own.
module ueta_hub_model (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire ueta_pkg::ueta_target_s target_i,
   output logic      [15:0]            split_token_o
);
   import ueta_pkg::*;
   logic [15:0] token_next;
   always_comb begin
      token_next = 16'h0000;
      if (target_i.split_enable) begin
         token_next = {target_i.hub_address, target_i.hub_port, target_i.multi_translator, 1'b1};
      end
   end
   always_ff @(posedge clk_i) begin
      split_token_o <= rst_i ? 16'h0000 : token_next;
   end
endmodule

// [test/test_usb_endpoint_target_addressing.sv]
`timescale 1ns/1ns
module test_usb_endpoint_target_addressing;
   import ueta_pkg::*;
   logic         clk_i = 1'b0;
   logic         rst_i = 1'b1;
   logic         cyc = 1'b0;
   logic         stb = 1'b0;
   logic         we = 1'b0;
   logic [5:0]   adr = 6'h00;
   logic [3:0]   sel = 4'hF;
   logic [31:0]  dat = 32'h00000000;
   logic [31:0]  q;
   logic [31:0]  dat_o;
   logic         ack;
   logic [15:0]  fifo_ofs;
   logic [15:0]  tx_tok;
   ueta_target_s tx_t;
   ueta_target_s rx_t;
   int           miscompares = 0;
   int           num_checks = 0;
   int           cycles = 0;
   logic [5:0]   ofs [8] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C};
   logic [31:0]  ones [8] = '{32'h1FFF, 32'h7F, 32'hFF, 32'h7F, 32'h7F, 32'hFF, 32'h7F, 32'h3};

   ueta_regs ueta_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .rx_fifo_byte_offset_o(fifo_ofs), .tx_target_o(tx_t), .rx_target_o(rx_t));
   ueta_hub_model ueta_hub_model_inst (.clk_i(clk_i), .rst_i(rst_i), .target_i(tx_t),
      .split_token_o(tx_tok));

   always #2 clk_i = ~clk_i;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Classic single cycle; the request is held until ack is sampled high or 20 cycles pass.
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) check(32'h0, 32'h1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         complete_run();
      end
   end

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         xfer(1'b0, ofs[i], 32'h0, 4'hF);
         check(q, 32'h0);
      end
      check({16'h0, fifo_ofs}, 32'h0);
      check({16'h0, tx_tok}, 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, ofs[i], 32'hFFFFFFFF, 4'hF);
         xfer(1'b0, ofs[i], 32'h0, 4'hF);
         check(q, ones[i]);
      end
      check({16'h0, fifo_ofs}, 32'hFFF8);
      check({9'h0, rx_t}, {9'h0, 7'h7F, 7'h7F, 7'h7F, 2'b11});
      check({16'h0, tx_tok}, 32'h0000FFFF);
      xfer(1'b1, 6'h20, 32'hFFFFFFFF, 4'hF);
      xfer(1'b0, 6'h20, 32'h0, 4'hF);
      check(q, 32'h0);
      $display("test field widths done");
      xfer(1'b1, 6'h00, 32'h0, 4'hF);
      xfer(1'b1, 6'h00, 32'h1FFF, 4'h1);
      xfer(1'b0, 6'h00, 32'h0, 4'hF);
      check(q, 32'hFF);
      check({16'h0, fifo_ofs}, 32'h7F8);
      $display("test byte lanes done");
      xfer(1'b1, 6'h04, 32'h11, 4'hF);
      xfer(1'b1, 6'h08, 32'h85, 4'hF);
      xfer(1'b1, 6'h0C, 32'h23, 4'hF);
      xfer(1'b1, 6'h1C, 32'h1, 4'hF);
      xfer(1'b1, 6'h10, 32'h22, 4'hF);
      xfer(1'b1, 6'h14, 32'h06, 4'hF);
      xfer(1'b1, 6'h18, 32'h44, 4'hF);
      xfer(1'b0, 6'h18, 32'h0, 4'hF);
      check({16'h0, tx_tok}, {16'h0, 7'h05, 7'h23, 2'b11});
      check({25'h0, tx_t.function_address}, 32'h11);
      check({9'h0, rx_t}, {9'h0, 7'h22, 7'h06, 7'h44, 2'b00});
      $display("test target outputs done");
      complete_run();
   end
endmodule
